// >>> design/jtag_test_port.sv
// Test access port controller with return clock on a shared single-wire pin
//
// What this block does
// RL1: Test reset low forces the controller to its reset state, no clock needed.
// RL2: Serial test output changes only on falling test clock edges, or when test reset clears it.
// RL3: Serial test input is captured on rising test clock edges.
// RL4: Mode select sampled on rising test clock edges steps the controller.
// RL5: Controller select is latched on test reset release and held until next.
// RL6: Debugger keeps controller select high at reset release; low is factory only.
// RL7: Device drives a return test clock back to the debugger.
// RL8: Return clock and single-wire function share one pin, never both.
// RL9: Standard sixteen-state controller; five high mode-select samples reach reset.
// RL10: Return clock follows the test clock after synchronising into system clock.
`timescale 1ns/1ps
module jtag_test_port #(
   parameter logic [31:0] ID_VALUE = 32'h0000_0001 // Arbitrary identity value
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic tck,
   input wire logic trst_b,
   input wire logic tms,
   input wire logic tdi,
   input wire logic jtag_select,
   output logic tdo,
   output logic tdo_oe,
   output logic debug_selected,
   input wire logic single_wire_en,
   input wire logic single_wire_out,
   input wire logic single_wire_oe,
   output logic single_wire_rx,
   input wire logic shared_pin_in,
   output logic shared_pin_out,
   output logic shared_pin_oe
);
   // ----------------------------------------------------------------
   // Controller select
   // ----------------------------------------------------------------
   // Clocked by the reset release itself; no other path changes it
   always_ff @(posedge trst_b) begin
      debug_selected <= jtag_select; // RL5
   end

   // ----------------------------------------------------------------
   // State machine on the test clock
   // ----------------------------------------------------------------
   jtag_test_port_pkg::tap_state_t state;
   jtag_test_port_pkg::tap_state_t next_state;
   logic [3:0] ir;
   logic [3:0] next_ir;
   logic [3:0] ir_shift;
   logic [3:0] next_ir_shift;
   logic [31:0] dr_shift;
   logic [31:0] next_dr_shift;
   // High from the second test clock edge after release; the first edge still
   // compares against the select value from before the test reset
   logic tck_run;
   logic next_tck_run;

   always_comb begin
      next_tck_run = 1'b1;
      next_state = state;
      case (state)
         jtag_test_port_pkg::S_TLR: next_state = tms ? jtag_test_port_pkg::S_TLR
                                                     : jtag_test_port_pkg::S_RTI;
         jtag_test_port_pkg::S_RTI: next_state = tms ? jtag_test_port_pkg::S_SEL_DR
                                                     : jtag_test_port_pkg::S_RTI;
         jtag_test_port_pkg::S_SEL_DR: next_state = tms ? jtag_test_port_pkg::S_SEL_IR
                                                        : jtag_test_port_pkg::S_CAP_DR;
         jtag_test_port_pkg::S_CAP_DR, jtag_test_port_pkg::S_SHIFT_DR: begin
            next_state = tms ? jtag_test_port_pkg::S_EXIT1_DR : jtag_test_port_pkg::S_SHIFT_DR;
         end
         jtag_test_port_pkg::S_EXIT1_DR: next_state = tms ? jtag_test_port_pkg::S_UPD_DR
                                                          : jtag_test_port_pkg::S_PAUSE_DR;
         jtag_test_port_pkg::S_PAUSE_DR: next_state = tms ? jtag_test_port_pkg::S_EXIT2_DR
                                                          : jtag_test_port_pkg::S_PAUSE_DR;
         jtag_test_port_pkg::S_EXIT2_DR: next_state = tms ? jtag_test_port_pkg::S_UPD_DR
                                                          : jtag_test_port_pkg::S_SHIFT_DR;
         jtag_test_port_pkg::S_UPD_DR, jtag_test_port_pkg::S_UPD_IR: begin
            next_state = tms ? jtag_test_port_pkg::S_SEL_DR : jtag_test_port_pkg::S_RTI;
         end
         jtag_test_port_pkg::S_SEL_IR: next_state = tms ? jtag_test_port_pkg::S_TLR
                                                        : jtag_test_port_pkg::S_CAP_IR;
         jtag_test_port_pkg::S_CAP_IR, jtag_test_port_pkg::S_SHIFT_IR: begin
            next_state = tms ? jtag_test_port_pkg::S_EXIT1_IR : jtag_test_port_pkg::S_SHIFT_IR;
         end
         jtag_test_port_pkg::S_EXIT1_IR: next_state = tms ? jtag_test_port_pkg::S_UPD_IR
                                                          : jtag_test_port_pkg::S_PAUSE_IR;
         jtag_test_port_pkg::S_PAUSE_IR: next_state = tms ? jtag_test_port_pkg::S_EXIT2_IR
                                                          : jtag_test_port_pkg::S_PAUSE_IR;
         jtag_test_port_pkg::S_EXIT2_IR: next_state = tms ? jtag_test_port_pkg::S_UPD_IR
                                                          : jtag_test_port_pkg::S_SHIFT_IR;
         default: next_state = jtag_test_port_pkg::S_TLR; // RL9
      endcase
   end

   always_comb begin
      next_ir = ir;
      next_ir_shift = ir_shift;
      next_dr_shift = dr_shift;
      case (state)
         jtag_test_port_pkg::S_TLR: next_ir = jtag_test_port_pkg::IR_RESET;
         jtag_test_port_pkg::S_CAP_IR: next_ir_shift = jtag_test_port_pkg::IR_CAPTURE;
         jtag_test_port_pkg::S_SHIFT_IR: next_ir_shift = {tdi, ir_shift[3:1]}; // RL3
         jtag_test_port_pkg::S_UPD_IR: next_ir = ir_shift;
         jtag_test_port_pkg::S_CAP_DR: begin
            next_dr_shift = (ir == jtag_test_port_pkg::INSTR_IDCODE) ? ID_VALUE : 32'h0000_0000;
         end
         jtag_test_port_pkg::S_SHIFT_DR: begin
            // Any instruction but the identity one acts as a one-bit bypass
            if (ir == jtag_test_port_pkg::INSTR_IDCODE) begin
               next_dr_shift = {tdi, dr_shift[31:1]}; // RL3
            end else begin
               next_dr_shift = {31'h0000_0000, tdi}; // RL3
            end
         end
         default: next_ir = ir;
      endcase
   end

   always_ff @(posedge tck or negedge trst_b) begin
      if (!trst_b) begin
         state <= jtag_test_port_pkg::S_TLR; // RL1
         ir <= jtag_test_port_pkg::IR_RESET;
         ir_shift <= 4'h0;
         dr_shift <= 32'h0000_0000;
         tck_run <= 1'b0;
      end else begin
         state <= next_state; // RL4
         ir <= next_ir;
         ir_shift <= next_ir_shift;
         dr_shift <= next_dr_shift;
         tck_run <= next_tck_run;
      end
   end

   // ----------------------------------------------------------------
   // Serial output on the falling edge
   // ----------------------------------------------------------------
   logic next_tdo;
   logic next_tdo_oe;

   always_comb begin
      next_tdo = 1'b0;
      next_tdo_oe = 1'b0;
      if (state == jtag_test_port_pkg::S_SHIFT_IR) begin
         next_tdo = ir_shift[0];
         next_tdo_oe = debug_selected;
      end else if (state == jtag_test_port_pkg::S_SHIFT_DR) begin
         next_tdo = dr_shift[0];
         next_tdo_oe = debug_selected;
      end
   end

   // Half a period of setup for the debugger's rising-edge sample
   always_ff @(negedge tck or negedge trst_b) begin
      if (!trst_b) begin
         tdo <= 1'b0;
         tdo_oe <= 1'b0;
      end else begin
         tdo <= next_tdo; // RL2
         tdo_oe <= next_tdo_oe;
      end
   end

   // ----------------------------------------------------------------
   // Return clock and shared single-wire pin
   // ----------------------------------------------------------------
   logic [1:0] sync2;
   logic [1:0] sync3;
   logic tck_seen;
   logic next_tck_seen;
   logic next_single_wire_rx;
   logic next_pin_out;
   logic next_pin_oe;

   pin_sync #(.WIDTH(2)) u_pin_sync (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .async_in({shared_pin_in, tck}),
      .stage2(sync2),
      .stage3(sync3)
   );

   always_comb begin
      next_tck_seen = (sync2[0] == sync3[0]) ? sync3[0] : tck_seen; // RL10
      next_single_wire_rx = (sync2[1] == sync3[1]) ? sync3[1] : single_wire_rx;
      // Return clock lags by the sync delay, which is what pacing debuggers expect
      if (single_wire_en) begin
         next_pin_out = single_wire_out; // RL8
         next_pin_oe = single_wire_oe; // RL8
      end else begin
         next_pin_out = tck_seen; // RL7
         next_pin_oe = 1'b1; // RL7
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tck_seen <= 1'b0;
         single_wire_rx <= 1'b0;
         shared_pin_out <= 1'b0;
         shared_pin_oe <= 1'b0;
      end else begin
         tck_seen <= next_tck_seen;
         single_wire_rx <= next_single_wire_rx;
         shared_pin_out <= next_pin_out;
         shared_pin_oe <= next_pin_oe;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence five_high_s;
      tms [*5];
   endsequence

   sequence exit_ir_step_s;
      (state == jtag_test_port_pkg::S_EXIT1_IR) && tms;
   endsequence

   // Watched on the system clock, since the test clock stands still during test reset
   reset_state_a: assert property (@(posedge clk_sys) !trst_b |-> // RL1
      state == jtag_test_port_pkg::S_TLR) else $error("Controller not in reset under test reset");
   tdo_timing_a: assert property (@(posedge tck) disable iff (!trst_b) // RL2
      (state == jtag_test_port_pkg::S_SHIFT_DR && debug_selected) |-> tdo_oe && tdo == dr_shift[0])
      else $error("Serial output not set up on falling edge");
   bypass_capture_a: assert property (@(posedge tck) disable iff (!trst_b) // RL3
      (state == jtag_test_port_pkg::S_SHIFT_DR && ir != jtag_test_port_pkg::INSTR_IDCODE)
      |=> dr_shift[0] == $past(tdi)) else $error("Bypass bit did not take serial input");
   ir_advance_a: assert property (@(posedge tck) disable iff (!trst_b) // RL4
      exit_ir_step_s |=> state == jtag_test_port_pkg::S_UPD_IR)
      else $error("Mode select did not advance to update");
   select_hold_a: assert property (@(posedge tck) disable iff (!trst_b) // RL5
      tck_run |-> $stable(debug_selected))
      else $error("Controller select changed without reset release");
   five_reset_a: assert property (@(posedge tck) disable iff (!trst_b) // RL9
      five_high_s |-> ##0 1'b1 ##1 state == jtag_test_port_pkg::S_TLR)
      else $error("Five high mode-select samples did not reach reset");
   return_clock_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL10
      (!single_wire_en && $changed(tck_seen)) |=> shared_pin_out == $past(tck_seen) && shared_pin_oe)
      else $error("Return clock did not follow synchronised test clock");
   pin_share_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // RL8
      single_wire_en |=> shared_pin_out == $past(single_wire_out)
      && shared_pin_oe == $past(single_wire_oe)) else $error("Return clock leaked onto shared pin");
endmodule

// >>> design/pin_sync.sv
// Three-stage synchroniser for levels arriving from outside the system clock
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 2
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] stage2,
   output logic [WIDTH-1:0] stage3
);
   logic [WIDTH-1:0] stage1;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end else begin
         stage1 <= async_in;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end
endmodule

// >>> pkg/jtag_test_port_pkg.sv
// Shared constants for the test access port block
package jtag_test_port_pkg;
   localparam int IR_WIDTH = 4;
   localparam int DR_WIDTH = 32;
   localparam logic [3:0] INSTR_IDCODE = 4'h1;
   localparam logic [3:0] INSTR_BYPASS = 4'hF;
   localparam logic [3:0] IR_RESET = INSTR_IDCODE;
   localparam logic [3:0] IR_CAPTURE = 4'h1;
   localparam int SYNC_STAGES = 3;
   localparam int RESET_TMS_COUNT = 5;

   typedef enum logic [3:0] {
      S_TLR, S_RTI, S_SEL_DR, S_CAP_DR, S_SHIFT_DR, S_EXIT1_DR, S_PAUSE_DR, S_EXIT2_DR,
      S_UPD_DR, S_SEL_IR, S_CAP_IR, S_SHIFT_IR, S_EXIT1_IR, S_PAUSE_IR, S_EXIT2_IR, S_UPD_IR
   } tap_state_t;
endpackage

// >>> testbench/jtag_debugger_model.sv
// Debugger model that drives the test port pins at its own pace
`timescale 1ns/1ps
module jtag_debugger_model (
   output logic tck,
   output logic trst_b,
   output logic tms,
   output logic tdi,
   output logic jtag_select,
   input wire logic tdo
);
   initial begin
      tck = 1'b0;
      // Starts released so that the first test reset is a real falling edge
      trst_b = 1'b1;
      tms = 1'b1;
      tdi = 1'b0;
      jtag_select = 1'b1;
   end
   // Test clock stands still between frames; 30 ns period inside them
   task automatic run(input int n, input logic [63:0] tms_v, input logic [63:0] tdi_v,
      output logic [63:0] got);
      got = '0;
      for (int i = 0; i < n; i++) begin
         #1 tms = tms_v[i];
         tdi = tdi_v[i];
         #14 tck = 1'b1;
         got[i] = tdo;
         #15 tck = 1'b0;
      end
      // Inverted data line shows no stale value; the pause lets falling-edge outputs settle
      #1 tdi = ~tdi;
   endtask
   task automatic test_reset(input logic sel);
      trst_b = 1'b0;
      jtag_select = sel;
      #40 trst_b = 1'b1;
      #20 jtag_select = ~sel;
   endtask
   task automatic set_tck(input logic v);
      tck = v;
   endtask
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench for the test access port block
`timescale 1ns/1ps
module tb_top;
   localparam logic [31:0] ID = 32'hC3A5_5A3C; // Arbitrary identity value
   logic clk_sys = 1'b0;
   logic rst_b = 1'b1;
   logic tck, trst_b, tms, tdi, jtag_select, tdo, tdo_oe, debug_selected;
   logic single_wire_en = 1'b0, single_wire_out = 1'b0, single_wire_oe = 1'b0;
   logic shared_pin_in = 1'b1;
   logic single_wire_rx, shared_pin_out, shared_pin_oe;
   int fails = 0, checks_done = 0, seed = 32'hce4b;
   logic [63:0] got;
   logic [31:0] data, want, d;
   bit q[$];
   always #5 clk_sys = ~clk_sys;
   jtag_test_port #(.ID_VALUE(ID)) i_jtag_test_port (.clk_sys, .rst_b, .tck, .trst_b, .tms,
      .tdi, .jtag_select, .tdo, .tdo_oe, .debug_selected, .single_wire_en, .single_wire_out,
      .single_wire_oe, .single_wire_rx, .shared_pin_in, .shared_pin_out, .shared_pin_oe);
   jtag_debugger_model i_jtag_debugger_model (.tck, .trst_b, .tms, .tdi, .jtag_select, .tdo);
   task automatic check(input logic [31:0] seen, input logic [31:0] w);
      checks_done++;
      if (seen !== w) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, w);
      end
   endtask
   // From idle: walk to shift, move n bits LSB first, return to idle
   task automatic shift(input bit ir, input int n, input logic [31:0] din,
      output logic [31:0] dout);
      int pre;
      logic [63:0] tv, g;
      pre = ir ? 4 : 3;
      tv = ir ? 64'h3 : 64'h1;
      tv[pre+n-1] = 1'b1;
      tv[pre+n] = 1'b1;
      i_jtag_debugger_model.run(pre + n + 2, tv, 64'(din) << pre, g);
      dout = 32'((g >> pre) & ((64'h1 << n) - 1));
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      // A real falling edge, so the asynchronous reset branches run
      #1 rst_b = 1'b0;
      wait_clk(3);
      rst_b = 1'b1;
      i_jtag_debugger_model.test_reset(1'b1);
      check(debug_selected, 32'h1);
      check(tdo_oe, 32'h0);
      i_jtag_debugger_model.run(1, 64'h0, 64'h0, got);
      data = $random(seed);
      shift(1'b0, 32, data, d);
      check(d, ID);
      $display("test identity read done");
      shift(1'b1, 4, 32'hF, d);
      check(d, 32'(jtag_test_port_pkg::IR_CAPTURE));
      data = $random(seed);
      q = {1'b0};
      for (int i = 0; i < 32; i++) q.push_back(data[i]);
      for (int i = 0; i < 32; i++) want[i] = q.pop_front();
      shift(1'b0, 32, data, d);
      check(d, want);
      $display("test bypass done");
      i_jtag_debugger_model.run(6, 64'h1F, 64'h0, got);
      shift(1'b0, 32, data, d);
      check(d, ID);
      i_jtag_debugger_model.run(4, 64'h1, 64'h0, got);
      check(tdo_oe, 32'h1);
      i_jtag_debugger_model.test_reset(1'b0);
      check(tdo_oe, 32'h0);
      check(debug_selected, 32'h0);
      i_jtag_debugger_model.run(5, 64'h2, 64'h0, got);
      check(tdo_oe, 32'h0);
      i_jtag_debugger_model.test_reset(1'b1);
      check(debug_selected, 32'h1);
      $display("test async reset and select done");
      wait_clk(2);
      check(shared_pin_oe, 32'h1);
      check(shared_pin_out, 32'h0);
      i_jtag_debugger_model.set_tck(1'b1);
      wait_clk(3);
      check(shared_pin_out, 32'h0);
      wait_clk(3);
      check(shared_pin_out, 32'h1);
      i_jtag_debugger_model.set_tck(1'b0);
      single_wire_en = 1'b1;
      for (int i = 0; i < 4; i++) begin
         {single_wire_out, single_wire_oe, shared_pin_in} = 3'($random(seed));
         i_jtag_debugger_model.set_tck(i[0]);
         wait_clk(6);
         check(shared_pin_out, 32'(single_wire_out));
         check(shared_pin_oe, 32'(single_wire_oe));
         check(single_wire_rx, 32'(shared_pin_in));
      end
      $display("test shared pin done");
      tally_and_finish;
   end
   initial begin
      #100000;
      fails++;
      tally_and_finish;
   end
endmodule
